// ### dv/dpmhc_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the loop control block
module dpmhc_properties
   import dpmhc_pkg::*;
(
   input wire logic            clock,
   input wire logic            nrst,
   input wire logic            ce,
   input wire dpmhc_host_req_t hostReq,
   input wire logic [7:0]      hostRdData,
   input wire logic            hostRdValid,
   input wire logic            refPresent,
   input wire logic [3:0]      monFail,
   input wire logic            loopLockDetect,
   input wire dpmhc_loop_cfg_t loopCfg,
   input wire logic            realignPulse,
   input wire logic            holdoverActive,
   input wire logic            lockedActive,
   input wire logic            oscOnly
);
   logic [7:0]  ctl_q;
   logic [7:0]  ctl_d;
   logic [1:0]  mode_q;
   logic [1:0]  mode_d;
   logic [19:0] bwExp;
   logic [17:0] slExp;
   logic        wrMode;
   logic        pulseCause;
   // Shadow register decode
   assign wrMode     = ce && hostReq.wrEn && hostReq.addr == ADDR_LOOP_MODE_SEL;
   assign pulseCause = ce && hostReq.wrEn && hostReq.addr == ADDR_LOOP_CONTROL && hostReq.wrData[4];
   assign ctl_d = (ce && hostReq.wrEn && hostReq.addr == ADDR_LOOP_CONTROL) ?
                  {hostReq.wrData[7:2], 2'h0} : ctl_q;
   assign mode_d = (wrMode && hostReq.wrData[1:0] != MODE_RESERVED) ? hostReq.wrData[1:0] : mode_q;
   assign bwExp  = (ctl_q[7:5] == BW_NARROW_CODE) ? BW_NARROW_MHZ : BW_BASE_MHZ << ctl_q[7:5];
   assign slExp  = (ctl_q[3:2] == 2'h0) ? {1'b0, SLOPE_CODE0_NSPS} :
                   (ctl_q[3:2] == 2'h1) ? {1'b0, SLOPE_CODE1_NSPS} :
                   (ctl_q[3:2] == 2'h2) ? {1'b0, SLOPE_CODE2_NSPS} : 18'h20000;
   // Shadow copies of control and mode
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctl_q  <= RST_LOOP_CONTROL;
         mode_q <= MODE_AUTO;
      end else begin
         ctl_q  <= ctl_d;
         mode_q <= mode_d;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence sWrCtl;
      ce && hostReq.wrEn && hostReq.addr == ADDR_LOOP_CONTROL;
   endsequence
   sequence sRdSts;
      ce && hostReq.rdEn && hostReq.addr == ADDR_LOOP_STATE;
   endsequence
   AST_REALIGN_SET: assert property (sWrCtl ##0 hostReq.wrData[4] |=> realignPulse)
      else $error("realign pulse missing after write");
   AST_REALIGN_CAUSE: assert property (realignPulse |-> $past(pulseCause))
      else $error("realign pulse without write");
   AST_SLOPE: assert property (ce |=>
      {loopCfg.slopeUnlimited, loopCfg.slopeLimitNsps} == $past(slExp))
      else $error("slope limit decode wrong");
   AST_BW: assert property (ce |=> loopCfg.bandwidthMhz == $past(bwExp))
      else $error("bandwidth decode wrong");
   AST_FORCED: assert property (ce && mode_q == MODE_FORCED |=>
      holdoverActive && !lockedActive)
      else $error("forced mode not in holdover");
   AST_FREERUN: assert property (ce && mode_q == MODE_FREERUN |=>
      oscOnly && !holdoverActive)
      else $error("free-run not on oscillator");
   AST_AUTO_HOLD: assert property (ce && mode_q == MODE_AUTO && !refPresent |=>
      holdoverActive)
      else $error("auto mode missed holdover");
   AST_AUTO_LOCK: assert property (ce && mode_q == MODE_AUTO && refPresent
      && monFail == 4'h0 && loopLockDetect |=> lockedActive && !holdoverActive && !oscOnly)
      else $error("auto mode missed lock");
   AST_HOLD_STS: assert property (sRdSts ##0 $past(holdoverActive) |=> hostRdData[0])
      else $error("holdover status not set");
   AST_LOCK_STS: assert property (sRdSts ##0 $past(lockedActive) |=> hostRdData[1])
      else $error("lock status not set");
   AST_STS_RSVD: assert property (sRdSts |=> hostRdValid && hostRdData[7:2] == 6'h00)
      else $error("status reserved bits or valid wrong");
endmodule
bind dpmhc_mode_holdover_ctrl dpmhc_properties i_dpmhc_properties (
   .clock(clock), .nrst(nrst), .ce(ce), .hostReq(hostReq), .hostRdData(hostRdData),
   .hostRdValid(hostRdValid), .refPresent(refPresent), .monFail(monFail),
   .loopLockDetect(loopLockDetect), .loopCfg(loopCfg), .realignPulse(realignPulse),
   .holdoverActive(holdoverActive), .lockedActive(lockedActive), .oscOnly(oscOnly));

// ### dv/dpmhc_ref_model.sv
`timescale 1ns/1ps
// ==========================================================
// Reference side: monitors and a lock detector with acquisition delay
module dpmhc_ref_model
   import dpmhc_pkg::*;
#(
   parameter int LOCK_DLY = 3
)
(
   input  wire logic       clock,
   input  wire logic       refOk,
   input  wire logic       lockOk,
   input  wire logic [3:0] fail,
   output logic            refPresent,
   output logic [3:0]      monFail,
   output logic            loopLockDetect
);
   logic [3:0] cnt_q = 4'h0;
   // Monitors follow the commanded reference condition
   assign refPresent     = refOk;
   assign monFail        = fail;
   assign loopLockDetect = (cnt_q == 4'(LOCK_DLY));
   // Lock only after the reference stays good for a while
   always_ff @(posedge clock) begin
      cnt_q <= !(refOk && lockOk) ? 4'h0 : (loopLockDetect ? cnt_q : cnt_q + 4'h1);
   end
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Bench top
module testbench import dpmhc_pkg::*;;
   logic            clock, nrst, ce, refOk, lockOk, hostRdValid, refPresent, loopLockDetect;
   logic            realignPulse, holdoverActive, lockedActive, oscOnly;
   logic [3:0]      fail, monFail;
   logic [7:0]      hostRdData;
   dpmhc_host_req_t hostReq;
   dpmhc_loop_cfg_t loopCfg;
   logic [17:0]     slope [4];
   int              errors, comparisons;
   dpmhc_mode_holdover_ctrl i_dpmhc_mode_holdover_ctrl (.clock(clock), .nrst(nrst), .ce(ce),
      .hostReq(hostReq), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
      .refPresent(refPresent), .monFail(monFail), .loopLockDetect(loopLockDetect),
      .loopCfg(loopCfg), .realignPulse(realignPulse), .holdoverActive(holdoverActive),
      .lockedActive(lockedActive), .oscOnly(oscOnly));
   dpmhc_ref_model i_dpmhc_ref_model (.clock(clock), .refOk(refOk), .lockOk(lockOk),
      .fail(fail), .refPresent(refPresent), .monFail(monFail), .loopLockDetect(loopLockDetect));
   // ==========================================================
   // Access and check tasks
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clock);
      hostReq <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      hostReq <= '0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clock);
      hostReq <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      hostReq <= '0;
      #1;
      chk("hostRdValid", 1, hostRdValid);
      chk($sformatf("read %0h", a), e, hostRdData);
   endtask
   task automatic env(logic r, logic l, logic [3:0] f, logic [2:0] e);
      @(posedge clock);
      refOk  <= r;
      lockOk <= l;
      fail   <= f;
      repeat (6) @(posedge clock);
      #1;
      chk("flags", e, {oscOnly, holdoverActive, lockedActive});
   endtask
   task automatic close_out;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Clock and watchdog
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #50000;
      errors++;
      close_out();
   end
   // Main sequence
   initial begin
      slope = '{{1'b0, SLOPE_CODE0_NSPS}, {1'b0, SLOPE_CODE1_NSPS}, {1'b0, SLOPE_CODE2_NSPS},
                18'h20000};
      {nrst, ce, refOk, lockOk, fail, hostReq} = {4'b0111, 4'h0, 18'h00000};
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      rd(ADDR_LOOP_STATE, RST_LOOP_STATE);
      rd(ADDR_LOOP_CONTROL, RST_LOOP_CONTROL);
      rd(ADDR_LOOP_MODE_SEL, RST_LOOP_MODE_SEL);
      rd(ADDR_HOLD_TRIG_MSK, RST_HOLD_TRIG_MSK);
      rd(ADDR_PHASE_MEM, RST_PHASE_MEM);
      rd(8'h00, 8'h00);
      @(posedge clock);
      #1;
      chk("hostRdValid", 0, hostRdValid);
      wr(ADDR_LOOP_CONTROL, 8'hFF);
      chk("realignPulse", 1, realignPulse);
      rd(ADDR_LOOP_CONTROL, 8'hFC);
      wr(ADDR_HOLD_TRIG_MSK, 8'hFF);
      rd(ADDR_HOLD_TRIG_MSK, 8'h8F);
      wr(ADDR_LOOP_MODE_SEL, 8'hFE);
      rd(ADDR_LOOP_MODE_SEL, 8'h03);
      // Loop stays locked, so the sticky lock bit reads back set
      wr(ADDR_LOOP_STATE, 8'hFF);
      rd(ADDR_LOOP_STATE, 8'h02);
      // Code for a limit well above half a reference period
      wr(ADDR_PHASE_MEM, 8'h5A);
      rd(ADDR_PHASE_MEM, 8'h5A);
      chk("phaseMemCode", 8'h5A, loopCfg.phaseMemCode);
      // Every bandwidth and slope code, realign on odd codes
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_LOOP_CONTROL, {k[2:0], k[0], k[1:0], 2'h0});
         chk("realignPulse", k[0], realignPulse);
         @(posedge clock);
         #1;
         chk("realignPulse", 0, realignPulse);
         chk("bandwidthMhz", k == 7 ? BW_NARROW_MHZ : BW_BASE_MHZ << k,
             loopCfg.bandwidthMhz);
         chk("slope", slope[k[1:0]],
             {loopCfg.slopeUnlimited, loopCfg.slopeLimitNsps});
      end
      // Modes, then sticky status
      wr(ADDR_LOOP_MODE_SEL, {6'h00, MODE_FREERUN});
      env(1'b1, 1'b1, 4'h0, 3'b100);
      wr(ADDR_LOOP_MODE_SEL, {6'h00, MODE_FORCED});
      env(1'b1, 1'b1, 4'h0, 3'b010);
      wr(ADDR_LOOP_MODE_SEL, {6'h00, MODE_AUTO});
      env(1'b1, 1'b1, 4'h0, 3'b001);
      rd(ADDR_LOOP_STATE, 8'h03);
      rd(ADDR_LOOP_STATE, 8'h02);
      env(1'b0, 1'b1, 4'h0, 3'b010);
      rd(ADDR_LOOP_STATE, 8'h03);
      rd(ADDR_LOOP_STATE, 8'h01);
      // Each monitor enabled alone (guard timer enabled with coarse rate), then each masked alone
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_HOLD_TRIG_MSK, 8'(8'h80 | (1 << i) | (i == 3 ? 4 : 0)));
         env(1'b1, 1'b1, 4'(1 << i), 3'b010);
         wr(ADDR_HOLD_TRIG_MSK, 8'(8'h8F ^ (1 << i)));
         env(1'b1, 1'b1, 4'(1 << i), 3'b001);
      end
      close_out();
   end
endmodule

// ### hdl/dpmhc_loop_fsm.sv
`timescale 1ns/1ps
module dpmhc_loop_fsm
   import dpmhc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       ce,
   input  wire logic [1:0] mode,
   input  wire logic       refUsable,
   input  wire logic       lockDetect,
   output logic            holdover,
   output logic            locked,
   output logic            oscOnly
);

   typedef enum logic [1:0] {FREERUN, ACQUIRE, LOCKED, HOLDOVER} dpmhc_state_t;

   dpmhc_state_t state_q;
   dpmhc_state_t state_d;

   // ==========================================================
   // Next loop state
   always_comb begin
      state_d = state_q;
      unique case (mode)
         MODE_FREERUN: state_d = FREERUN;                    // [RULE7]
         MODE_FORCED:  state_d = HOLDOVER;                   // [RULE6]
         MODE_AUTO: begin
            if (!refUsable) begin
               state_d = HOLDOVER;                           // [RULE5]
            end else if (lockDetect) begin
               state_d = LOCKED;                             // [RULE5]
            end else begin
               state_d = ACQUIRE;
            end
         end
         default: state_d = state_q;                         // [RULE4]
      endcase
   end

   // State and flag registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q  <= FREERUN;
         holdover <= 1'b0;
         locked   <= 1'b0;
         oscOnly  <= 1'b1;
      end else if (ce) begin
         state_q  <= state_d;
         holdover <= (state_d == HOLDOVER);
         locked   <= (state_d == LOCKED);
         oscOnly  <= (state_d == FREERUN);                   // [RULE7]
      end
   end

endmodule

// ### hdl/dpmhc_mode_holdover_ctrl.sv
// Operation
// [RULE1] Control bits 3:2 pick slope cap 61, 7.5, 0.885 us/s or unlimited.
// [RULE2] Setting control bit 4 requests output phase alignment to the reference.
// [RULE3] Control bits 7:5 pick bandwidth 14 Hz doubling to 896 Hz; 111 is 30 mHz.
// [RULE4] Mode field: 00 free-run, 01 forced holdover, 11 automatic; 10 is forbidden.
// [RULE5] Automatic mode locks while reference is usable, holds over when it is not.
// [RULE6] Forced holdover ignores the reference and holds over.
// [RULE7] Free-run derives outputs only from the local oscillator input.
// [RULE8] A cleared trigger bit stops its monitor from forcing holdover.
// [RULE9] Trigger bits: 0 signal loss, 1 single period, 2 coarse rate, 3 guard timer.
// [RULE10] Software never enables guard timer trigger without coarse rate or single period.
// [RULE11] Sticky read-only status bit 0 sets while in holdover, unmasked, resets zero.
// [RULE12] Sticky status bit 1 sets while locked to a reference, unmasked.
// [RULE13] Software writes phase memory code as round(32*log(limit*1e5)).
// [RULE14] Phase memory limit is at least half a reference clock period.
// [RULE15] Reserved bits hold their reset values; writes to them do nothing.
`timescale 1ns/1ps
module dpmhc_mode_holdover_ctrl
   import dpmhc_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             ce,
   input  wire dpmhc_host_req_t  hostReq,
   output logic [7:0]            hostRdData,
   output logic                  hostRdValid,
   input  wire logic             refPresent,
   input  wire logic [3:0]       monFail,
   input  wire logic             loopLockDetect,
   output dpmhc_loop_cfg_t       loopCfg,
   output logic                  realignPulse,
   output logic                  holdoverActive,
   output logic                  lockedActive,
   output logic                  oscOnly
);

   // ==========================================================
   // Registers
   logic [7:0]      control_q;
   logic [7:0]      control_d;
   logic [7:0]      modeSel_q;
   logic [7:0]      modeSel_d;
   logic [7:0]      trigMask_q;
   logic [7:0]      trigMask_d;
   logic [7:0]      phaseMem_q;
   logic [7:0]      phaseMem_d;
   logic [7:0]      status_q;
   logic [7:0]      status_d;
   logic [7:0]      rdData_d;
   logic            realign_d;
   dpmhc_loop_cfg_t cfg_d;

   // ==========================================================
   // Address decode
   wire         wrControl  = hostReq.wrEn && (hostReq.addr == ADDR_LOOP_CONTROL);
   wire         wrModeSel  = hostReq.wrEn && (hostReq.addr == ADDR_LOOP_MODE_SEL);
   wire         wrTrigMask = hostReq.wrEn && (hostReq.addr == ADDR_HOLD_TRIG_MSK);
   wire         wrPhaseMem = hostReq.wrEn && (hostReq.addr == ADDR_PHASE_MEM);
   wire         rdStatus   = hostReq.rdEn && (hostReq.addr == ADDR_LOOP_STATE);
   wire [1:0]   wrMode     = hostReq.wrData[MODE_MSB:MODE_LSB];
   wire         modeLegal  = (wrMode != MODE_RESERVED);

   // Write merge: only defined fields take the written data
   assign control_d  = wrControl ?
                       {hostReq.wrData[7:2], RST_LOOP_CONTROL[1:0]} : control_q;   // [RULE15]
   assign modeSel_d  = (wrModeSel && modeLegal) ?
                       {RST_LOOP_MODE_SEL[7:2], wrMode} : modeSel_q;               // [RULE4]
   assign trigMask_d = wrTrigMask ?
                       {RST_HOLD_TRIG_MSK[7:4], hostReq.wrData[TRIG_MSB:TRIG_LSB]}
                       : trigMask_q;                                                // [RULE15]
   assign phaseMem_d = wrPhaseMem ? hostReq.wrData : phaseMem_q;
   assign realign_d  = wrControl && hostReq.wrData[REALIGN_BIT];                   // [RULE2]

   // ==========================================================
   // Holdover triggers: a monitor counts only when its mask bit is one
   wire [3:0] trigHit;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_trig
         assign trigHit[gi] = monFail[gi] && trigMask_q[TRIG_LSB + gi];            // [RULE8]
      end
   endgenerate
   wire refUsable = refPresent && !(|trigHit);                                      // [RULE9]

   // ==========================================================
   // Sticky status: set wins over clear-on-read, reserved bits stay zero
   wire [1:0] stsSet = {lockedActive, holdoverActive};
   wire [1:0] stsClr = {2{rdStatus}};
   assign status_d = {RST_LOOP_STATE[7:2],
                      stsSet | (status_q[LOCK_STS_BIT:HOLD_STS_BIT] & ~stsClr)};   // [RULE11] [RULE12]

   // ==========================================================
   // Read mux, unmapped addresses read zero
   always_comb begin
      unique case (hostReq.addr)
         ADDR_LOOP_CONTROL:  rdData_d = control_q;
         ADDR_LOOP_MODE_SEL: rdData_d = modeSel_q;
         ADDR_HOLD_TRIG_MSK: rdData_d = trigMask_q;
         ADDR_LOOP_STATE:    rdData_d = status_q;
         ADDR_PHASE_MEM:     rdData_d = phaseMem_q;
         default:            rdData_d = 8'h00;
      endcase
   end

   // ==========================================================
   // Loop configuration decode
   wire [1:0] slopeCode = control_q[SLOPE_MSB:SLOPE_LSB];
   wire [2:0] bwCode    = control_q[BW_MSB:BW_LSB];
   always_comb begin
      cfg_d                = '0;
      cfg_d.slopeUnlimited = (slopeCode == SLOPE_UNLIMITED);                       // [RULE1]
      unique case (slopeCode)
         2'h0:    cfg_d.slopeLimitNsps = SLOPE_CODE0_NSPS;                         // [RULE1]
         2'h1:    cfg_d.slopeLimitNsps = SLOPE_CODE1_NSPS;                         // [RULE1]
         2'h2:    cfg_d.slopeLimitNsps = SLOPE_CODE2_NSPS;                         // [RULE1]
         default: cfg_d.slopeLimitNsps = '0;
      endcase
      cfg_d.bandwidthMhz = (bwCode == BW_NARROW_CODE) ?
                           BW_NARROW_MHZ : (BW_BASE_MHZ << bwCode);                // [RULE3]
      cfg_d.phaseMemCode = phaseMem_q;
   end

   // ==========================================================
   // Register file
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         control_q  <= RST_LOOP_CONTROL;
         modeSel_q  <= RST_LOOP_MODE_SEL;
         trigMask_q <= RST_HOLD_TRIG_MSK;
         phaseMem_q <= RST_PHASE_MEM;
         status_q   <= RST_LOOP_STATE;
      end else if (ce) begin
         control_q  <= control_d;
         modeSel_q  <= modeSel_d;
         trigMask_q <= trigMask_d;
         phaseMem_q <= phaseMem_d;
         status_q   <= status_d;
      end
   end

   // Output registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         hostRdData   <= 8'h00;
         hostRdValid  <= 1'b0;
         realignPulse <= 1'b0;
         loopCfg      <= '0;
      end else if (ce) begin
         hostRdData   <= hostReq.rdEn ? rdData_d : hostRdData;
         hostRdValid  <= hostReq.rdEn;
         realignPulse <= realign_d;                                                 // [RULE2]
         loopCfg      <= cfg_d;
      end
   end

   // ==========================================================
   // Loop mode state machine
   dpmhc_loop_fsm u_fsm (
      .clock      (clock),
      .nrst       (nrst),
      .ce         (ce),
      .mode       (modeSel_q[MODE_MSB:MODE_LSB]),
      .refUsable  (refUsable),
      .lockDetect (loopLockDetect),
      .holdover   (holdoverActive),
      .locked     (lockedActive),
      .oscOnly    (oscOnly)
   );

endmodule

// ### hdl/dpmhc_pkg.sv
package dpmhc_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_LOOP_CONTROL  = 8'h30;
   localparam logic [7:0] ADDR_LOOP_MODE_SEL = 8'h33;
   localparam logic [7:0] ADDR_HOLD_TRIG_MSK = 8'h34;
   localparam logic [7:0] ADDR_LOOP_STATE    = 8'h35;
   localparam logic [7:0] ADDR_PHASE_MEM     = 8'h47;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_LOOP_CONTROL  = 8'h0C;
   localparam logic [7:0] RST_LOOP_MODE_SEL = 8'h03;
   localparam logic [7:0] RST_HOLD_TRIG_MSK = 8'h87;
   localparam logic [7:0] RST_LOOP_STATE    = 8'h00;
   localparam logic [7:0] RST_PHASE_MEM     = 8'h0A;

   // ==========================================================
   // Field positions
   localparam int SLOPE_LSB    = 2;
   localparam int SLOPE_MSB    = 3;
   localparam int REALIGN_BIT  = 4;
   localparam int BW_LSB       = 5;
   localparam int BW_MSB       = 7;
   localparam int MODE_LSB     = 0;
   localparam int MODE_MSB     = 1;
   localparam int TRIG_LSB     = 0;
   localparam int TRIG_MSB     = 3;
   localparam int HOLD_STS_BIT = 0;
   localparam int LOCK_STS_BIT = 1;

   // Holdover trigger bit order
   localparam int TRIG_SIGNAL_LOSS = 0;
   localparam int TRIG_SINGLE_PER  = 1;
   localparam int TRIG_COARSE_RATE = 2;
   localparam int TRIG_GUARD_TIMER = 3;

   // ==========================================================
   // Mode codes
   localparam logic [1:0] MODE_FREERUN  = 2'h0;
   localparam logic [1:0] MODE_FORCED   = 2'h1;
   localparam logic [1:0] MODE_RESERVED = 2'h2;
   localparam logic [1:0] MODE_AUTO     = 2'h3;

   // ==========================================================
   // Slope limits in ns/s, bandwidth in mHz
   localparam logic [16:0] SLOPE_CODE0_NSPS = 17'h0EE48;  // 61 us/s
   localparam logic [16:0] SLOPE_CODE1_NSPS = 17'h01D4C;  // 7.5 us/s
   localparam logic [16:0] SLOPE_CODE2_NSPS = 17'h00375;  // 0.885 us/s
   localparam logic [1:0]  SLOPE_UNLIMITED  = 2'h3;
   localparam logic [19:0] BW_BASE_MHZ      = 20'h036B0;  // 14 Hz
   localparam logic [19:0] BW_NARROW_MHZ    = 20'h0001E;  // 30 mHz
   localparam logic [2:0]  BW_NARROW_CODE   = 3'h7;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } dpmhc_host_req_t;

   typedef struct packed {
      logic        slopeUnlimited;
      logic [16:0] slopeLimitNsps;
      logic [19:0] bandwidthMhz;
      logic [7:0]  phaseMemCode;
   } dpmhc_loop_cfg_t;

endpackage
